// ### hdl/rrr_regulator_registers.sv
// module: regulator control, readback and peak strength registers on axi4-lite
//
// Behaviour
// - bit 7 picks calibrated or host code
// - 5 V mode: 3.6 V plus 0.1 V steps
// - 5 V mode: digital/analog supplies at 3.4 V
// - 3.3 V mode: digital/analog follow rf supply
// - bits 2..0 pick measured rail, 11x reserved
// - readback bits 7..4 show calibrated code
// - readback bit 0 shows rf current limit
// - am peak code held in bits 7..4
// - pm peak code held in bits 3..0
// - codes follow logarithmic level thresholds
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module rrr_regulator_registers (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic supply_mode_5v,
  input wire logic rf_current_limited,
  input wire logic calibrate_done,
  input wire logic [3:0] calibrated_code,
  input wire logic reception_start,
  input wire logic peak_strength_clear_cmd,
  input wire logic level_valid,
  input wire logic [10:0] am_level_mv,
  input wire logic [10:0] pm_level_mv,
  input wire logic supply_measure_cmd,
  output logic [3:0] regulator_code,
  output logic [12:0] rf_supply_mv,
  output logic [12:0] core_supply_mv,
  output logic regulator_code_undefined,
  output logic [2:0] measure_rail_sel,
  output logic measure_strobe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // all registers of the block
  typedef struct packed {
    logic aw_have; // write address latched
    logic [11:0] aw_addr;
    logic w_have; // write data latched
    logic [7:0] w_data; // only the low lane is stored
    logic w_lane0; // low byte strobe
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl; // regulator_voltage_control
    logic [3:0] cal_code; // last calibration result
    logic [1:0] ilim_sync; // pin synchroniser
    logic ilim_q; // for edge detection
    logic [1:0] mode_sync; // pin synchroniser
    logic [3:0] am; // am peak code
    logic [3:0] pm; // pm peak code
    logic [rrr_pkg::EV_N-1:0] status; // sticky events
    logic [rrr_pkg::EV_N-1:0] mask;
    logic [3:0] reg_code;
    logic [12:0] rf_mv;
    logic [12:0] core_mv;
    logic code_undef;
    logic [2:0] meas_sel;
    logic meas_strobe;
    logic irq;
  } rrr_state_t;

  rrr_state_t s; // current state
  rrr_state_t next_s; // next state
  logic [3:0] eff_code; // code steering the regulators
  logic mode5; // synchronised 5 V mode
  logic [3:0] am_new; // fresh am code
  logic [3:0] pm_new; // fresh pm code
  logic peak_clr; // reception start or clear command
  logic [rrr_pkg::EV_N-1:0] ev; // events this cycle
  logic [rrr_pkg::EV_N-1:0] w1c; // bits written one to status

  ////////////////////////////////////////////////////////////////////////////
  // derived terms

  // source of the regulator code
  assign eff_code = s.ctrl[rrr_pkg::SRC_BIT] ? s.ctrl[rrr_pkg::EXT_LSB +: 4] : s.cal_code;
  assign mode5 = s.mode_sync[1];
  assign am_new = rrr_pkg::strength_code(am_level_mv);
  assign pm_new = rrr_pkg::strength_code(pm_level_mv);
  assign peak_clr = reception_start | peak_strength_clear_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // one combinational pass for all state
  always_comb begin
    next_s = s;
    ev = '0;
    w1c = '0;
    next_s.meas_strobe = 1'b0;
    // pin synchronisers
    next_s.ilim_sync = {s.ilim_sync[0], rf_current_limited};
    next_s.mode_sync = {s.mode_sync[0], supply_mode_5v};
    next_s.ilim_q = s.ilim_sync[1];
    // calibration result capture
    if (calibrate_done) begin
      next_s.cal_code = calibrated_code;
      ev[rrr_pkg::EV_CAL] = 1'b1;
    end
    // current limit onset
    ev[rrr_pkg::EV_ILIM] = s.ilim_sync[1] & ~s.ilim_q;
    // regulator voltages
    next_s.reg_code = eff_code;
    next_s.code_undef = 1'b0;
    if (mode5) begin
      next_s.rf_mv = rrr_pkg::V5_BASE_MV + rrr_pkg::STEP_MV * {9'h000, eff_code};
      next_s.core_mv = rrr_pkg::CORE_5V_MV;
    end else begin
      if (eff_code >= rrr_pkg::V33_FIRST_CODE) begin
        next_s.rf_mv = rrr_pkg::V33_BASE_MV
          + rrr_pkg::STEP_MV * {9'h000, eff_code - rrr_pkg::V33_FIRST_CODE};
      end else begin
        // no defined voltage, hold the lowest and flag it
        next_s.rf_mv = rrr_pkg::V33_BASE_MV;
        next_s.code_undef = 1'b1;
      end
      next_s.core_mv = next_s.rf_mv;
    end
    // supply measurement command
    if (supply_measure_cmd && s.ctrl[rrr_pkg::MEAS_LSB +: 3] < rrr_pkg::MEAS_FIRST_RESERVED) begin
      next_s.meas_sel = s.ctrl[rrr_pkg::MEAS_LSB +: 3];
      next_s.meas_strobe = 1'b1;
    end
    // peak strength tracking, clear wins over a sample
    if (peak_clr) begin
      next_s.am = 4'h0;
      next_s.pm = 4'h0;
    end else if (level_valid) begin
      if (am_new > s.am) begin
        next_s.am = am_new;
        ev[rrr_pkg::EV_PEAK] = 1'b1;
      end
      if (pm_new > s.pm) begin
        next_s.pm = pm_new;
        ev[rrr_pkg::EV_PEAK] = 1'b1;
      end
    end
    // write channels, taken in either order
    if (s.awready && awvalid) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (s.wready && wvalid) begin
      next_s.w_have = 1'b1;
      next_s.w_data = wdata[7:0];
      next_s.w_lane0 = wstrb[0];
    end
    // perform the write once both halves are here
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rrr_pkg::RESP_OKAY;
      unique case (s.aw_addr)
        rrr_pkg::ADDR_REG_CTRL: begin
          if (s.w_lane0) begin
            next_s.ctrl = s.w_data;
          end
        end
        rrr_pkg::ADDR_IRQ_STATUS: begin
          if (s.w_lane0) begin
            w1c = s.w_data[rrr_pkg::EV_N-1:0];
          end
        end
        rrr_pkg::ADDR_IRQ_MASK: begin
          if (s.w_lane0) begin
            next_s.mask = s.w_data[rrr_pkg::EV_N-1:0];
          end
        end
        // read-only registers ignore writes
        rrr_pkg::ADDR_REG_READBACK, rrr_pkg::ADDR_STRENGTH: begin
          next_s.bresp = rrr_pkg::RESP_OKAY;
        end
        default: begin
          next_s.bresp = rrr_pkg::RESP_SLVERR;
        end
      endcase
    end
    // response handshake
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    // read channel
    if (s.arready && arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = rrr_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      unique case (araddr)
        rrr_pkg::ADDR_REG_CTRL: begin
          next_s.rdata[7:0] = s.ctrl;
        end
        rrr_pkg::ADDR_REG_READBACK: begin
          next_s.rdata[rrr_pkg::CAL_LSB +: 4] = s.cal_code;
          next_s.rdata[rrr_pkg::ILIM_BIT] = s.ilim_sync[1];
        end
        rrr_pkg::ADDR_STRENGTH: begin
          next_s.rdata[rrr_pkg::AM_LSB +: 4] = s.am;
          next_s.rdata[rrr_pkg::PM_LSB +: 4] = s.pm;
        end
        rrr_pkg::ADDR_IRQ_STATUS: begin
          next_s.rdata[rrr_pkg::EV_N-1:0] = s.status;
        end
        rrr_pkg::ADDR_IRQ_MASK: begin
          next_s.rdata[rrr_pkg::EV_N-1:0] = s.mask;
        end
        default: begin
          next_s.rresp = rrr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
    // sticky status, a new event wins over its clear
    next_s.status = (s.status & ~w1c) | ev;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= rrr_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign regulator_code = s.reg_code;
  assign rf_supply_mv = s.rf_mv;
  assign core_supply_mv = s.core_mv;
  assign regulator_code_undefined = s.code_undef;
  assign measure_rail_sel = s.meas_sel;
  assign measure_strobe = s.meas_strobe;
  assign irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  host_code_sel_a: assert property (
    s.ctrl[rrr_pkg::SRC_BIT] |=> regulator_code == $past(s.ctrl[rrr_pkg::EXT_LSB +: 4]))
    else $error("host code not selected");
  cal_code_sel_a: assert property (
    !s.ctrl[rrr_pkg::SRC_BIT] |=> regulator_code == $past(s.cal_code))
    else $error("calibrated code not selected");
  rf_5v_scale_a: assert property (
    mode5 |=> rf_supply_mv == rrr_pkg::V5_BASE_MV + rrr_pkg::STEP_MV * {9'h000, regulator_code})
    else $error("5 V scale wrong");
  // sampled reset keeps the release edge, with outputs still cleared, out of the antecedent
  rf_33_undef_a: assert property (
    aresetn && !mode5 && eff_code < rrr_pkg::V33_FIRST_CODE |=> regulator_code_undefined)
    else $error("undefined 3.3 V code not flagged");
  core_5v_a: assert property (
    mode5 |=> core_supply_mv == rrr_pkg::CORE_5V_MV && !regulator_code_undefined)
    else $error("core supply not 3.4 V");
  core_follow_a: assert property (
    !mode5 |=> core_supply_mv == rf_supply_mv)
    else $error("core supply not following rf");
  meas_select_a: assert property (
    supply_measure_cmd && s.ctrl[2:0] < rrr_pkg::MEAS_FIRST_RESERVED
    |=> measure_strobe && measure_rail_sel == $past(s.ctrl[2:0]))
    else $error("measurement rail wrong");
  meas_reserved_a: assert property (
    supply_measure_cmd && s.ctrl[2:0] >= rrr_pkg::MEAS_FIRST_RESERVED |=> !measure_strobe)
    else $error("reserved rail started");
  cal_capture_a: assert property (
    calibrate_done |=> s.cal_code == $past(calibrated_code) && s.status[rrr_pkg::EV_CAL])
    else $error("calibration result lost");
  ilim_flag_a: assert property (
    rf_current_limited [*3] |=> s.ilim_sync[1])
    else $error("current limit not shown");
  peak_clear_a: assert property (
    peak_clr |=> s.am == 4'h0 && s.pm == 4'h0)
    else $error("peak codes not cleared");
  peak_code_a: assert property (
    level_valid && !peak_clr |=> s.am >= rrr_pkg::strength_code($past(am_level_mv))
      && s.pm >= rrr_pkg::strength_code($past(pm_level_mv)))
    else $error("peak below measured code");
  peak_hold_a: assert property (
    !peak_clr |=> s.am >= $past(s.am) && s.pm >= $past(s.pm))
    else $error("peak code decreased");
  status_set_a: assert property (
    |ev |=> (s.status & $past(ev)) == $past(ev))
    else $error("event lost against its clear");
  irq_raise_a: assert property (
    |(ev & s.mask) && !(s.aw_have && s.w_have) |=> irq)
    else $error("unmasked event did not raise irq");

  cal_seen_c: cover property (calibrate_done ##1 !s.ctrl[rrr_pkg::SRC_BIT]);
  peak_rise_c: cover property (level_valid && am_new > s.am ##3 rvalid && rready);
  irq_c: cover property ($rose(irq));
  write_read_c: cover property (bvalid && bready ##[1:8] rvalid && rready);

endmodule

// ### include/rrr_pkg.sv
// package: register map, field layout and scaling for the regulator/strength registers
package rrr_pkg;
  // axi address width
  localparam int unsigned AXI_ADDR_W = 12;
  // register indices as printed, byte address is four times the index, with SPACE_B_BASE added for the readback register
  localparam logic [7:0] IDX_REG_CTRL = 8'h2c;
  localparam logic [7:0] IDX_REG_READBACK = 8'h2c;
  localparam logic [7:0] IDX_STRENGTH = 8'h2d;
  // second register space starts here
  localparam logic [11:0] SPACE_B_BASE = 12'h100;
  localparam logic [11:0] ADDR_REG_CTRL = {2'h0, IDX_REG_CTRL, 2'h0};
  localparam logic [11:0] ADDR_REG_READBACK = SPACE_B_BASE | {2'h0, IDX_REG_READBACK, 2'h0};
  localparam logic [11:0] ADDR_STRENGTH = {2'h0, IDX_STRENGTH, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h000;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h004;
  // control register fields
  localparam int unsigned SRC_BIT = 7;
  localparam int unsigned EXT_LSB = 3;
  localparam int unsigned MEAS_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // readback and strength fields
  localparam int unsigned CAL_LSB = 4;
  localparam int unsigned ILIM_BIT = 0;
  localparam int unsigned AM_LSB = 4;
  localparam int unsigned PM_LSB = 0;
  // measurement rail codes, 6 and 7 reserved
  localparam logic [2:0] MEAS_FIRST_RESERVED = 3'h6;
  // voltage scaling in millivolts
  localparam logic [12:0] V5_BASE_MV = 13'h0e10;
  localparam logic [12:0] V33_BASE_MV = 13'h0960;
  localparam logic [12:0] STEP_MV = 13'h0064;
  localparam logic [12:0] CORE_5V_MV = 13'h0d48;
  localparam logic [3:0] V33_FIRST_CODE = 4'h5;
  // interrupt event bits
  localparam int unsigned EV_CAL = 0;
  localparam int unsigned EV_ILIM = 1;
  localparam int unsigned EV_PEAK = 2;
  localparam int unsigned EV_N = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // strength thresholds in mVrms, code is the count exceeded
  localparam logic [10:0] STRENGTH_MV [15] = '{11'h014, 11'h01b, 11'h025, 11'h034, 11'h048,
    11'h063, 11'h088, 11'h0be, 11'h106, 11'h165, 11'h1f4, 11'h2ae, 11'h3b6, 11'h47e, 11'h514};

  // level in mVrms to four-bit log code
  function automatic logic [3:0] strength_code(input logic [10:0] mv);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if (mv > STRENGTH_MV[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction
endpackage

// ### tb/test_rrr_regulator_registers.sv
// testbench: regulator control, readback and peak strength registers
`timescale 1ns/1ps
module test_rrr_regulator_registers;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic supply_mode_5v = 1'b0;
  logic rf_current_limited = 1'b0;
  logic [3:0] calibrated_code = 4'h0;
  logic [10:0] am_level_mv = 11'h000;
  logic [10:0] pm_level_mv = 11'h000;
  // pulses: cal done, rx start, peak clear, level valid, measure
  logic [4:0] pl = 5'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [3:0] regulator_code;
  logic [12:0] rf_supply_mv, core_supply_mv;
  logic regulator_code_undefined, measure_strobe, irq;
  logic [2:0] measure_rail_sel;
  // model of the held peak codes
  logic [3:0] am_max, pm_max;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int v;

  rrr_regulator_registers dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .supply_mode_5v,
    .rf_current_limited, .calibrate_done(pl[0]), .calibrated_code, .reception_start(pl[1]),
    .peak_strength_clear_cmd(pl[2]), .level_valid(pl[3]), .am_level_mv, .pm_level_mv,
    .supply_measure_cmd(pl[4]), .regulator_code, .rf_supply_mv, .core_supply_mv,
    .regulator_code_undefined, .measure_rail_sel, .measure_strobe, .irq);

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expectations and bus helpers
  function automatic logic [12:0] vexp(input logic m5, input int c);
    if (m5) return 13'(3600 + 100 * c);
    if (c < 5) return 13'(2400);
    return 13'(2400 + 100 * (c - 5));
  endfunction

  // level to log code, count of thresholds exceeded
  function automatic logic [3:0] scode(input int mv);
    int th [15] = '{20, 27, 37, 52, 72, 99, 136, 190, 262, 357, 500, 686, 950, 1150, 1300};
    scode = 4'h0;
    for (int i = 0; i < 15; i++) if (mv > th[i]) scode = 4'(i + 1);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // write one word, hold each channel until taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
      end
    end
  endtask

  task automatic rdr(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rdr(a, rrr_pkg::RESP_OKAY, d);
    chk(d, e, "read data");
  endtask

  task automatic pulse(input int i);
    @(posedge aclk);
    pl[i] <= 1'b1;
    @(posedge aclk);
    pl[i] <= 1'b0;
  endtask

  // let registered outputs land, look mid-cycle
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  // one level sample, model keeps the larger code
  task automatic lvl(input int am, input int pm);
    @(posedge aclk);
    am_level_mv <= 11'(am);
    pm_level_mv <= 11'(pm);
    pulse(3);
    if (scode(am) > am_max) am_max = scode(am);
    if (scode(pm) > pm_max) pm_max = scode(pm);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(85));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset value and an unmapped place
    rchk(rrr_pkg::ADDR_REG_CTRL, 32'h0);
    rdr(12'h0f0, rrr_pkg::RESP_SLVERR, rd);
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
    // every host code in both supply modes
    for (int m = 1; m >= 0; m--) begin
      @(posedge aclk);
      supply_mode_5v <= m[0];
      for (int c = 0; c < 16; c++) begin
        wr(rrr_pkg::ADDR_REG_CTRL, {1'b1, 4'(c), 3'h0}, rrr_pkg::RESP_OKAY);
        settle();
        chk(32'(regulator_code), c, "host code");
        chk(32'(rf_supply_mv), 32'(vexp(m[0], c)), "rf supply");
        chk(32'(core_supply_mv), m ? 3400 : 32'(vexp(1'b0, c)), "core supply");
        chk(32'(regulator_code_undefined), 32'(m == 0 && c < 5), "undefined");
      end
    end
    rchk(rrr_pkg::ADDR_REG_CTRL, 32'hf8);
    // low lane strobe off writes nothing, unmapped write refused
    wstrb <= 4'h0;
    wr(rrr_pkg::ADDR_REG_CTRL, 8'h00, rrr_pkg::RESP_OKAY);
    wstrb <= 4'h1;
    wr(12'h0f0, 8'h00, rrr_pkg::RESP_SLVERR);
    rchk(rrr_pkg::ADDR_REG_CTRL, 32'hf8);
    $display("test host codes done");
    // calibrated source, readback and current limit
    wr(rrr_pkg::ADDR_REG_CTRL, 8'h00, rrr_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      v = $urandom_range(15, 0);
      calibrated_code <= 4'(v);
      rf_current_limited <= i[0];
      pulse(0);
      settle();
      chk(32'(regulator_code), v, "calibrated code");
      rchk(rrr_pkg::ADDR_REG_READBACK, {24'h0, 4'(v), 3'h0, i[0]});
    end
    // calibration done and current limit onset both latched
    rchk(rrr_pkg::ADDR_IRQ_STATUS, 32'h3);
    $display("test calibration done");
    // every measurement selection, reserved ones refused
    for (int s = 0; s < 8; s++) begin
      wr(rrr_pkg::ADDR_REG_CTRL, {5'h00, 3'(s)}, rrr_pkg::RESP_OKAY);
      pulse(4);
      @(negedge aclk);
      chk(32'(measure_strobe), 32'(s < 6), "measure strobe");
      if (s < 6) chk(32'(measure_rail_sel), s, "rail select");
    end
    $display("test measure done");
    // peak codes: corners, then random, then both clears
    pulse(2);
    am_max = 4'h0;
    pm_max = 4'h0;
    for (int i = 0; i < 14; i++) begin
      v = (i < 4) ? ((i == 0) ? 20 : (i == 1) ? 1150 : (i == 2) ? 1300 : 100)
                  : $urandom_range(1400, 0);
      lvl(v, (i < 4) ? v + 1 : $urandom_range(1400, 0));
      rchk(rrr_pkg::ADDR_STRENGTH, {24'h0, am_max, pm_max});
    end
    pulse(1);
    rchk(rrr_pkg::ADDR_STRENGTH, 32'h0);
    lvl(500, 500);
    pulse(2);
    rchk(rrr_pkg::ADDR_STRENGTH, 32'h0);
    am_max = 4'h0;
    pm_max = 4'h0;
    $display("test peaks done");
    // interrupt: raise, mask, unmask, clear
    wr(rrr_pkg::ADDR_IRQ_STATUS, 8'h07, rrr_pkg::RESP_OKAY);
    wr(rrr_pkg::ADDR_IRQ_MASK, 8'h04, rrr_pkg::RESP_OKAY);
    settle();
    chk(32'(irq), 32'h0, "irq idle");
    lvl(1400, 1400);
    settle();
    chk(32'(irq), 32'h1, "irq raised");
    rdr(rrr_pkg::ADDR_IRQ_STATUS, rrr_pkg::RESP_OKAY, rd);
    chk(32'(rd[2]), 32'h1, "peak status");
    wr(rrr_pkg::ADDR_IRQ_MASK, 8'h00, rrr_pkg::RESP_OKAY);
    settle();
    chk(32'(irq), 32'h0, "irq masked");
    wr(rrr_pkg::ADDR_IRQ_MASK, 8'h04, rrr_pkg::RESP_OKAY);
    settle();
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(rrr_pkg::ADDR_IRQ_STATUS, 8'h04, rrr_pkg::RESP_OKAY);
    settle();
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
